// *** hw/switch_lookup_override_vlan_cmd.sv ***
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`include "swe_lookup_map.svh"
module switch_lookup_override_vlan_cmd (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [17:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // forwarding path: lookup result per ingress port
  input wire logic [2:0] lookup_valid_i,
  input wire logic [8:0] lookup_dest_i,
  input wire logic [8:0] lookup_attr_i,
  output swe_lookup_pkg::port_mask_t dest0_o,
  output swe_lookup_pkg::port_mask_t dest1_o,
  output swe_lookup_pkg::port_mask_t dest2_o,
  output logic [8:0] attr_o,
  output logic [2:0] fwd_valid_o,
  // forwarding restriction mask per ingress port
  input wire logic [8:0] allowed_i,
  // vlan table access
  output logic tbl_req_o,
  output logic tbl_read_o,
  output logic tbl_pvid_o,
  output logic [3:0] tbl_index_o,
  output logic [17:0] tbl_wdata_o,
  input wire logic tbl_done_i,
  input wire logic [17:0] tbl_rdata_i
);
  import swe_lookup_pkg::*;

  logic [31:0] ovr_q;
  logic [31:0] cmd_q;
  logic [31:0] wrd_q;
  logic [31:0] rdd_q;
  acc_state_t st_q;
  acc_state_t st_d;
  logic [3:0] cnt_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  wire setup = psel_i && !penable_i;
  wire wr = setup && pwrite_i;
  wire rd = setup && !pwrite_i;
  wire hit_ovr = paddr_i == `OVR_ADDR;
  wire hit_cmd = paddr_i == `CMD_ADDR;
  wire hit_sts = paddr_i == `STS_ADDR;
  wire hit_rdd = paddr_i == `RDD_ADDR;
  wire hit_wrd = paddr_i == `WRD_ADDR;
  wire mapped = hit_ovr || hit_cmd || hit_sts || hit_rdd || hit_wrd;
  wire cmd_wr = wr && hit_cmd;
  wire pending = st_q == ST_BUSY;
  wire acc_done = pending && (tbl_done_i || cnt_q == 4'h0);
  wire [31:0] rd_mux = hit_ovr ? ovr_q : hit_cmd ? cmd_q : hit_sts ? {31'h0, pending} :
                       hit_rdd ? rdd_q : hit_wrd ? wrd_q : 32'h0;

  // answer one cycle after setup: pready rises in the access phase
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q <= rd ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ovr_q <= 32'h0;
      cmd_q <= 32'h0;
      wrd_q <= 32'h0;
    end else begin
      if (wr && hit_ovr) ovr_q <= pwdata_i & `OVR_MASK;
      if (cmd_wr) cmd_q <= pwdata_i & `CMD_MASK;
      if (wr && hit_wrd) wrd_q <= pwdata_i & `WRD_MASK;
    end
  end

  // a new command during a pending one restarts the access
  always_comb begin
    st_d = st_q;
    if (cmd_wr) st_d = ST_BUSY;
    else if (acc_done) st_d = ST_IDLE;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rdd_q <= 32'h0;
      tbl_req_o <= 1'b0;
      tbl_read_o <= 1'b0;
      tbl_pvid_o <= 1'b0;
      tbl_index_o <= 4'h0;
      tbl_wdata_o <= 18'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cmd_wr ? `TABLE_ACC_CYC : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      tbl_req_o <= cmd_wr;
      if (cmd_wr) begin
        tbl_read_o <= pwdata_i[`CMD_DIR_BIT];
        tbl_pvid_o <= pwdata_i[`CMD_TBL_BIT];
        tbl_index_o <= pwdata_i[3:0];
        tbl_wdata_o <= wrd_q[17:0];
      end
      if (acc_done && cmd_q[`CMD_DIR_BIT]) rdd_q <= {14'h0, tbl_rdata_i};
    end
  end

  // per-port override and restriction
  logic [2:0] dest_n [3];
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      wire en = ovr_q[4*p];
      wire [1:0] code = ovr_q[4*p+2 -: 2];
      wire [2:0] ovr_mask = (p == 0) ? {code == 2'b10, code == 2'b01, 1'b0} :
                            (p == 1) ? {code == 2'b10, 1'b0, code == 2'b00} :
                                       {1'b0, code == 2'b01, code == 2'b00};
      wire [2:0] sel = en ? ovr_mask : lookup_dest_i[3*p +: 3];
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) dest_n[p] <= 3'h0;
        else dest_n[p] <= sel & allowed_i[3*p +: 3];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      attr_o <= 9'h0;
      fwd_valid_o <= 3'h0;
    end else begin
      attr_o <= lookup_attr_i;
      fwd_valid_o <= lookup_valid_i;
    end
  end

  assign dest0_o = dest_n[0];
  assign dest1_o = dest_n[1];
  assign dest2_o = dest_n[2];
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // command launch and captured fields
  property p_launch;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_wr |=> tbl_req_o && pending;
  endproperty
  cmd_launch_a: assert property (p_launch) else $error("command write did not launch");

  property p_req_pulse;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !cmd_wr |=> !tbl_req_o;
  endproperty
  req_pulse_a: assert property (p_req_pulse) else $error("table request without command");

  property p_dir;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_wr |=> tbl_read_o == $past(pwdata_i[`CMD_DIR_BIT]);
  endproperty
  dir_bit_a: assert property (p_dir) else $error("direction wrong");

  property p_tbl_sel;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_wr |=> tbl_pvid_o == $past(pwdata_i[`CMD_TBL_BIT]);
  endproperty
  tbl_sel_a: assert property (p_tbl_sel) else $error("table select wrong");

  property p_index;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_wr |=> tbl_index_o == $past(pwdata_i[3:0]);
  endproperty
  index_fld_a: assert property (p_index) else $error("index wrong");

  property p_wdata;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_wr |=> tbl_wdata_o == $past(wrd_q[17:0]);
  endproperty
  wdata_copy_a: assert property (p_wdata) else $error("write data not forwarded");

  // reset and reserved bits
  property p_reset_zero;
    @(posedge core_clk_i)
    !rst_n_i |=> ovr_q == 32'h0;
  endproperty
  reset_zero_a: assert property (p_reset_zero) else $error("override not cleared");

  property p_reset_out;
    @(posedge core_clk_i)
    !rst_n_i |=> dest0_o == 3'h0 && dest1_o == 3'h0 && dest2_o == 3'h0 && !tbl_req_o;
  endproperty
  reset_out_a: assert property (p_reset_out) else $error("outputs not cleared");

  property p_rsvd;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ovr_q & ~`OVR_MASK) == 32'h0 && (cmd_q & ~`CMD_MASK) == 32'h0;
  endproperty
  rsvd_zero_a: assert property (p_rsvd) else $error("reserved bit set");

  // override selection per ingress port
  property p_p0_ovr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ovr_q[0] && ovr_q[2:1] == 2'b01 && allowed_i[2:0] == 3'h7 |=> dest0_o == 3'b010;
  endproperty
  p0_override_a: assert property (p_p0_ovr) else $error("port 0 override wrong");

  property p_p1_ovr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ovr_q[4] && ovr_q[6:5] == 2'b10 && allowed_i[5:3] == 3'h7 |=> dest1_o == 3'b100;
  endproperty
  p1_override_a: assert property (p_p1_ovr) else $error("port 1 override wrong");

  property p_p2_ovr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ovr_q[8] && ovr_q[10:9] == 2'b00 && allowed_i[8:6] == 3'h7 |=> dest2_o == 3'b001;
  endproperty
  p2_override_a: assert property (p_p2_ovr) else $error("port 2 override wrong");

  // reserved codes send nowhere rather than guess a port
  property p_p0_rsvd;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ovr_q[0] && (ovr_q[2:1] == 2'b00 || ovr_q[2:1] == 2'b11) |=> dest0_o == 3'h0;
  endproperty
  p0_reserved_a: assert property (p_p0_rsvd) else $error("port 0 reserved code forwarded");

  property p_p1_rsvd;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ovr_q[4] && ovr_q[5] |=> dest1_o == 3'h0;
  endproperty
  p1_reserved_a: assert property (p_p1_rsvd) else $error("port 1 reserved code forwarded");

  property p_p2_rsvd;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ovr_q[8] && ovr_q[10] |=> dest2_o == 3'h0;
  endproperty
  p2_reserved_a: assert property (p_p2_rsvd) else $error("port 2 reserved code forwarded");

  // lookup result passes when no override
  property p_no_ovr0;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !ovr_q[0] |=> dest0_o == ($past(lookup_dest_i[2:0]) & $past(allowed_i[2:0]));
  endproperty
  no_ovr_a: assert property (p_no_ovr0) else $error("lookup result not passed");

  property p_no_ovr1;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !ovr_q[4] |=> dest1_o == ($past(lookup_dest_i[5:3]) & $past(allowed_i[5:3]));
  endproperty
  no_ovr1_a: assert property (p_no_ovr1) else $error("port 1 lookup result not passed");

  property p_no_ovr2;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !ovr_q[8] |=> dest2_o == ($past(lookup_dest_i[8:6]) & $past(allowed_i[8:6]));
  endproperty
  no_ovr2_a: assert property (p_no_ovr2) else $error("port 2 lookup result not passed");

  property p_restrict;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (dest0_o & ~$past(allowed_i[2:0])) == 3'h0 && (dest1_o & ~$past(allowed_i[5:3])) == 3'h0 &&
      (dest2_o & ~$past(allowed_i[8:6])) == 3'h0;
  endproperty
  restrict_a: assert property (p_restrict) else $error("destination outside allowed mask");

  property p_attr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> attr_o == $past(lookup_attr_i);
  endproperty
  attr_kept_a: assert property (p_attr) else $error("attributes lost");

  property p_valid;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> fwd_valid_o == $past(lookup_valid_i);
  endproperty
  valid_kept_a: assert property (p_valid) else $error("forward valid lost");

  // pending lifetime and read capture
  property p_pend_bound;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_wr ##1 !cmd_wr [*5] |-> !pending;
  endproperty
  pend_bound_a: assert property (p_pend_bound) else $error("pending stuck");

  property p_pend_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    pending && !acc_done && !cmd_wr |=> pending;
  endproperty
  pend_hold_a: assert property (p_pend_hold) else $error("pending dropped early");

  property p_rdd;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    acc_done && cmd_q[`CMD_DIR_BIT] |=> rdd_q == {14'h0, $past(tbl_rdata_i)};
  endproperty
  rdd_capture_a: assert property (p_rdd) else $error("read data not captured");

  // bus answer
  property p_slverr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    setup && !mapped |=> pslverr_o && pready_o;
  endproperty
  slverr_map_a: assert property (p_slverr) else $error("unmapped access not flagged");

  property p_wr_rdata;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr |=> prdata_o == 32'h0;
  endproperty
  wr_rdata_a: assert property (p_wr_rdata) else $error("read data on a write");

  read_cmd_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) cmd_wr && pwdata_i[5]);
  write_cmd_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) cmd_wr && !pwdata_i[5]);
  pvid_cmd_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) cmd_wr && pwdata_i[4]);
  override_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) ovr_q[8] && lookup_valid_i[2]);
endmodule

// *** hw/swe_lookup_map.svh ***
`ifndef SWE_LOOKUP_MAP_SVH
`define SWE_LOOKUP_MAP_SVH

// register indexes; byte address is four times the index
`define OVR_IDX 16'h180a
`define CMD_IDX 16'h180b
`define WRD_IDX 16'h180c
`define STS_IDX 16'h180d
`define RDD_IDX 16'h180e
`define OVR_ADDR 18'h0_6028
`define CMD_ADDR 18'h0_602c
`define WRD_ADDR 18'h0_6030
`define STS_ADDR 18'h0_6034
`define RDD_ADDR 18'h0_6038
`define OVR_MASK 32'h0000_0777
`define CMD_MASK 32'h0000_003f
`define WRD_MASK 32'h0003_ffff
`define CMD_DIR_BIT 5
`define CMD_TBL_BIT 4
`define OVR_EN0_BIT 0
`define OVR_EN1_BIT 4
`define OVR_EN2_BIT 8
`define PORT_MAP_CODE0 2'h1
`define PORT_MAP_CODE1 2'h1
// table access times out this many cycles after the tbl_req_o pulse unless tbl_done_i ends it sooner
`define TABLE_ACC_CYC 4'h3
`endif

// *** hw/swe_lookup_pkg.sv ***
package swe_lookup_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } acc_state_t;
  typedef logic [2:0] port_mask_t;
endpackage

// *** verification/tb_switch_lookup_override_vlan_cmd.sv ***
`timescale 1ns/10ps
`include "swe_lookup_map.svh"
module tb_switch_lookup_override_vlan_cmd;
  import swe_lookup_pkg::*;
  logic core_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, tbl_done_i = 0;
  logic [17:0] paddr_i = '0, tbl_rdata_i = 18'h2a5a5, tbl_wdata_o;
  logic [31:0] pwdata_i = '0, prdata_o, r;
  logic pready_o, pslverr_o, tbl_req_o, tbl_read_o, tbl_pvid_o, e, q;
  logic [2:0] lookup_valid_i = '0, fwd_valid_o;
  logic [8:0] lookup_dest_i = '0, lookup_attr_i = '0, allowed_i = '0, attr_o;
  logic [3:0] tbl_index_o;
  port_mask_t dest0_o, dest1_o, dest2_o;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  // rows: override word, lookup result, allowed mask, expected {dest2,dest1,dest0}
  logic [31:0] ovr [4] = '{32'h0, 32'h353, 32'h531, 32'h115};
  logic [8:0] lk [4] = '{9'h053, 9'h1ff, 9'h1ff, 9'h1ff};
  logic [8:0] al [4] = '{9'h1f5, 9'h1ef, 9'h1ff, 9'h1ff};
  logic [8:0] xd [4] = '{9'h051, 9'h0a2, 9'h000, 9'h04c};
  logic [31:0] cmd [4] = '{32'h25, 32'h12, 32'hffff_ffe3, 32'h0f};

  switch_lookup_override_vlan_cmd DUT (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .lookup_valid_i, .lookup_dest_i, .lookup_attr_i,
    .dest0_o, .dest1_o, .dest2_o, .attr_o, .fwd_valid_o, .allowed_i, .tbl_req_o, .tbl_read_o,
    .tbl_pvid_o, .tbl_index_o, .tbl_wdata_o, .tbl_done_i, .tbl_rdata_i);

  initial forever #4 core_clk_i = ~core_clk_i;

  // whole run needs well under 1000 cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) n_mismatch++;
    r = prdata_o;
    e = pslverr_o;
    q = tbl_req_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask

  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1;
    apb(0, `OVR_ADDR, 0); chk("override reset", 0, r);
    apb(0, `CMD_ADDR, 0); chk("command reset", 0, r);
    apb(1, `OVR_ADDR, 32'hffff_ffff); apb(0, `OVR_ADDR, 0); chk("override mask", 32'h777, r);
    $display("test reset and masking done");
    for (int i = 0; i < 4; i++) begin
      apb(1, `OVR_ADDR, ovr[i]);
      @(posedge core_clk_i);
      lookup_valid_i <= 3'h7;
      lookup_dest_i <= lk[i];
      allowed_i <= al[i];
      lookup_attr_i <= 9'(i * 37 + 1);
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk("destinations", xd[i], {dest2_o, dest1_o, dest0_o});
      chk("attributes", 9'(i * 37 + 1), attr_o);
      chk("forward valid", 3'h7, fwd_valid_o);
    end
    $display("test override forwarding done");
    apb(1, `WRD_ADDR, 32'hfff3_1234); apb(0, `WRD_ADDR, 0); chk("write data", 32'h31234, r);
    foreach (cmd[i]) begin
      apb(1, `CMD_ADDR, cmd[i]); chk("table request", 1, q);
      chk("table access", cmd[i][5:0], {tbl_read_o, tbl_pvid_o, tbl_index_o});
      if (!cmd[i][5]) chk("table wdata", 18'h31234, tbl_wdata_o);
      apb(0, `STS_ADDR, 0); chk("pending set", 1, r[0]);
      for (int k = 0; k < 10 && r[0] !== 1'b0; k++) apb(0, `STS_ADDR, 0);
      chk("pending", 0, r[0]);
      if (cmd[i][5]) begin
        apb(0, `RDD_ADDR, 0); chk("read data", 18'h2a5a5, r);
      end
      apb(0, `CMD_ADDR, 0); chk("command reg", cmd[i] & 32'h3f, r);
    end
    $display("test table commands done");
    apb(0, 18'h0_6040, 0); chk("unmapped error", 1, e);
    apb(0, `OVR_ADDR, 0); chk("mapped no error", 0, e);
    $display("test address decode done");
    tally_and_finish();
  end
endmodule
